// ---- rssd_pkg.sv ----
package rssd_pkg;

	// ------------------------------------------------------------
	// Widths and constants
	// ------------------------------------------------------------
	localparam int unsigned RSSD_DATA_W   = 8;
	localparam int unsigned RSSD_ADDR_W   = 8;
	localparam int unsigned RSSD_MSB      = 7;
	localparam logic [7:0]  RSSD_ALL_ONES = 8'hff;
	localparam logic [7:0]  RSSD_ZERO     = 8'h00;
	localparam logic [7:0]  RSSD_STEP     = 8'h01;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [7:0]  RSSD_WORK_RST = 8'h00;
	localparam logic        RSSD_FLAG_RST = 1'b0;

	// ------------------------------------------------------------
	// Operation codes
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		RSSD_OP_NOP                             = 5'h00,
		RSSD_OP_ROTATE_LEFT_MEM                 = 5'h01,
		RSSD_OP_ROTATE_LEFT_TO_WORK             = 5'h02,
		RSSD_OP_ROTATE_LEFT_THRU_CARRY          = 5'h03,
		RSSD_OP_ROTATE_LEFT_THRU_CARRY_TO_WORK  = 5'h04,
		RSSD_OP_ROTATE_RIGHT_MEM                = 5'h05,
		RSSD_OP_ROTATE_RIGHT_TO_WORK            = 5'h06,
		RSSD_OP_ROTATE_RIGHT_THRU_CARRY         = 5'h07,
		RSSD_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK = 5'h08,
		RSSD_OP_MINUS_FROM_WORK                 = 5'h09,
		RSSD_OP_MINUS_IMM                       = 5'h0a,
		RSSD_OP_MINUS_INTO_MEM                  = 5'h0b,
		RSSD_OP_SUBTRACT_WITH_BORROW            = 5'h0c,
		RSSD_OP_SUBTRACT_WITH_BORROW_IMM        = 5'h0d,
		RSSD_OP_MINUS_BORROW_INTO_MEM           = 5'h0e,
		RSSD_OP_DECREMENT_SKIP_ZERO             = 5'h0f,
		RSSD_OP_DECREMENT_SKIP_TO_WORK          = 5'h10,
		RSSD_OP_INCREMENT_SKIP_ZERO             = 5'h11,
		RSSD_OP_INCREMENT_SKIP_TO_WORK          = 5'h12,
		RSSD_OP_SET_BYTE                        = 5'h13,
		RSSD_OP_SET_BIT                         = 5'h14,
		RSSD_OP_SKIP_IF_NONZERO                 = 5'h15,
		RSSD_OP_SKIP_IF_NONZERO_BIT             = 5'h16,
		RSSD_OP_SWAP_NIBBLES                    = 5'h17
	} rssd_op_type;

	// Gray-coded: normal cycle, then the cancelled second cycle of a skip.
	typedef enum logic [0:0] {
		RSSD_ST_RUN    = 1'b0,
		RSSD_ST_CANCEL = 1'b1
	} rssd_state_type;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic rssd_is_subtract(input rssd_op_type op);
		return op inside {RSSD_OP_MINUS_FROM_WORK, RSSD_OP_MINUS_IMM, RSSD_OP_MINUS_INTO_MEM,
			RSSD_OP_SUBTRACT_WITH_BORROW, RSSD_OP_SUBTRACT_WITH_BORROW_IMM,
			RSSD_OP_MINUS_BORROW_INTO_MEM};
	endfunction

	function automatic logic rssd_uses_borrow(input rssd_op_type op);
		return op inside {RSSD_OP_SUBTRACT_WITH_BORROW, RSSD_OP_SUBTRACT_WITH_BORROW_IMM,
			RSSD_OP_MINUS_BORROW_INTO_MEM};
	endfunction

	function automatic logic rssd_writes_work(input rssd_op_type op);
		return op inside {RSSD_OP_ROTATE_LEFT_TO_WORK, RSSD_OP_ROTATE_LEFT_THRU_CARRY_TO_WORK,
			RSSD_OP_ROTATE_RIGHT_TO_WORK, RSSD_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK,
			RSSD_OP_MINUS_FROM_WORK, RSSD_OP_MINUS_IMM, RSSD_OP_SUBTRACT_WITH_BORROW,
			RSSD_OP_SUBTRACT_WITH_BORROW_IMM, RSSD_OP_DECREMENT_SKIP_TO_WORK,
			RSSD_OP_INCREMENT_SKIP_TO_WORK};
	endfunction

	function automatic logic rssd_writes_mem(input rssd_op_type op);
		return op inside {RSSD_OP_ROTATE_LEFT_MEM, RSSD_OP_ROTATE_LEFT_THRU_CARRY,
			RSSD_OP_ROTATE_RIGHT_MEM, RSSD_OP_ROTATE_RIGHT_THRU_CARRY, RSSD_OP_MINUS_INTO_MEM,
			RSSD_OP_MINUS_BORROW_INTO_MEM, RSSD_OP_DECREMENT_SKIP_ZERO,
			RSSD_OP_INCREMENT_SKIP_ZERO, RSSD_OP_SET_BYTE, RSSD_OP_SET_BIT,
			RSSD_OP_SWAP_NIBBLES};
	endfunction

endpackage

// ---- rssd_subtractor.sv ----
`timescale 1ns/1ps

module rssd_subtractor
	import rssd_pkg::*;
(
	// Operands
	input  wire logic [7:0] minuend_in,
	input  wire logic [7:0] subtrahend_in,
	input  wire logic       carry_in,
	input  wire logic       use_borrow_in,
	// Result and flags
	output logic      [7:0] diff_out,
	output logic            carry_out,
	output logic            signed_wrap_out,
	output logic            half_borrow_out,
	output logic            signed_borrow_out,
	output logic            zero_out
);
	logic [8:0] wide;
	logic [4:0] low;
	logic       borrow_in;

	always_comb begin
		// Carry is an inverted borrow, so a clear carry takes one more away.
		borrow_in         = use_borrow_in & ~carry_in;
		wide              = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {8'h00, borrow_in};
		low               = {1'b0, minuend_in[3:0]} - {1'b0, subtrahend_in[3:0]}
			- {4'h0, borrow_in};
		diff_out          = wide[7:0];
		carry_out         = ~wide[8];
		half_borrow_out   = ~low[4];
		signed_wrap_out   = (minuend_in[RSSD_MSB] ^ subtrahend_in[RSSD_MSB])
			& (minuend_in[RSSD_MSB] ^ wide[RSSD_MSB]);
		// True sign of the signed difference, right even when it wrapped.
		signed_borrow_out = signed_wrap_out ^ wide[RSSD_MSB];
		zero_out          = (wide[7:0] == RSSD_ZERO);
	end

endmodule

// ---- rssd_unary_unit.sv ----
`timescale 1ns/1ps

module rssd_unary_unit
	import rssd_pkg::*;
(
	// Operation and operand
	input  rssd_pkg::rssd_op_type op_in,
	input  wire logic [7:0]       operand_in,
	input  wire logic             carry_in,
	input  wire logic [2:0]       bit_sel_in,
	// Result
	output logic      [7:0]       result_out,
	output logic                  carry_out,
	output logic                  skip_out
);
	logic [7:0] bit_mask;

	always_comb begin
		bit_mask   = RSSD_STEP << bit_sel_in;
		result_out = operand_in;
		carry_out  = carry_in;
		skip_out   = 1'b0;
		case (op_in)
			RSSD_OP_ROTATE_LEFT_MEM, RSSD_OP_ROTATE_LEFT_TO_WORK: begin
				result_out = {operand_in[6:0], operand_in[RSSD_MSB]};
			end
			RSSD_OP_ROTATE_LEFT_THRU_CARRY, RSSD_OP_ROTATE_LEFT_THRU_CARRY_TO_WORK: begin
				result_out = {operand_in[6:0], carry_in};
				carry_out  = operand_in[RSSD_MSB];
			end
			RSSD_OP_ROTATE_RIGHT_MEM, RSSD_OP_ROTATE_RIGHT_TO_WORK: begin
				result_out = {operand_in[0], operand_in[7:1]};
			end
			RSSD_OP_ROTATE_RIGHT_THRU_CARRY, RSSD_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK: begin
				result_out = {carry_in, operand_in[7:1]};
				carry_out  = operand_in[0];
			end
			RSSD_OP_DECREMENT_SKIP_ZERO, RSSD_OP_DECREMENT_SKIP_TO_WORK: begin
				result_out = operand_in - RSSD_STEP;
				skip_out   = (result_out == RSSD_ZERO);
			end
			RSSD_OP_INCREMENT_SKIP_ZERO, RSSD_OP_INCREMENT_SKIP_TO_WORK: begin
				result_out = operand_in + RSSD_STEP;
				skip_out   = (result_out == RSSD_ZERO);
			end
			RSSD_OP_SET_BYTE: begin
				result_out = RSSD_ALL_ONES;
			end
			RSSD_OP_SET_BIT: begin
				result_out = operand_in | bit_mask;
			end
			RSSD_OP_SKIP_IF_NONZERO: begin
				skip_out = (operand_in != RSSD_ZERO);
			end
			RSSD_OP_SKIP_IF_NONZERO_BIT: begin
				skip_out = ((operand_in & bit_mask) != RSSD_ZERO);
			end
			RSSD_OP_SWAP_NIBBLES: begin
				result_out = {operand_in[3:0], operand_in[7:4]};
			end
			default: begin
				result_out = operand_in;
			end
		endcase
	end

endmodule

// ---- rssd_datapath.sv ----
// Operation
// - Rotate left moves bit 7 to bit 0; flags unchanged.
// - Rotate left through carry: old carry to bit 0, bit 7 to carry.
// - Rotate right moves bit 0 to bit 7; flags unchanged.
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Rotates to the working register leave the memory byte untouched.
// - Subtraction carry is cleared on negative result, set on zero or positive.
// - Subtract with borrow: work minus operand minus inverted carry, into work.
// - Every subtract updates wrap, zero, half borrow, carry, signed borrow, chained null.
// - Memory-destination subtracts write the difference back to the memory byte.
// - Immediate subtract takes the embedded constant from work, result to work.
// - Immediate subtract with borrow also takes inverted carry, result to work.
// - Decrement-skip writes byte minus one back, skips on zero, no flags.
// - Decrement-skip to work puts result in work, memory unchanged, skips on zero.
// - Increment-skip writes byte plus one back, skips on wrap to zero, no flags.
// - Increment-skip to work puts result in work, memory unchanged, skips on zero.
// - A skip-type operation takes two instruction cycles when the skip is taken, one when it is not.
// - Byte set writes all ones to the memory byte, flags unchanged.
// - Bit set forces only the selected bit to one, flags unchanged.
// - Non-zero tests skip when byte or selected bit is non-zero; no flags.
// - Nibble swap exchanges upper and lower halves of the memory byte.
// - Nibble swap puts bits 7-4 in 3-0 and 3-0 in 7-4; no flags.
`timescale 1ns/1ps

module rssd_datapath
	import rssd_pkg::*;
#(
	parameter int unsigned ADDR_W = rssd_pkg::RSSD_ADDR_W
)(
	// Clock and reset
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	// Operation from the sequencer
	input  wire logic              op_valid_in,
	input  rssd_pkg::rssd_op_type  op_code_in,
	input  wire logic [ADDR_W-1:0] mem_addr_in,
	input  wire logic [7:0]        mem_rd_data_in,
	input  wire logic [7:0]        imm_data_in,
	input  wire logic [2:0]        bit_sel_in,
	// Data memory write-back
	output logic                   mem_wr_en_out,
	output logic      [ADDR_W-1:0] mem_wr_addr_out,
	output logic      [7:0]        mem_wr_data_out,
	// Sequencer handshake
	output logic                   ready_out,
	output logic                   done_out,
	output logic                   cancel_out,
	// Working register and status flags
	output logic      [7:0]        working_register_out,
	output logic                   carry_flag_out,
	output logic                   zero_flag_out,
	output logic                   signed_wrap_flag_out,
	output logic                   half_borrow_flag_out,
	output logic                   signed_borrow_flag_out,
	output logic                   chained_null_flag_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		rssd_state_type    state;
		logic              ready;
		logic              done;
		logic              cancel;
		logic              mem_we;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic [7:0]        work;
		logic              carry;
		logic              zero;
		logic              wrap;
		logic              half;
		logic              sborrow;
		logic              cnull;
	} rssd_regs_type;

	rssd_regs_type st_r;
	rssd_regs_type st_nxt;

	// ------------------------------------------------------------
	// Operand selection and arithmetic
	// ------------------------------------------------------------
	logic       take;
	logic       imm_form;
	logic [7:0] sub_rhs;
	logic [7:0] sub_diff;
	logic       sub_carry;
	logic       sub_wrap;
	logic       sub_half;
	logic       sub_sborrow;
	logic       sub_zero;
	logic [7:0] un_result;
	logic       un_carry;
	logic       un_skip;

	// An operation presented while the cancelled cycle runs is the instruction
	// being squashed, so it is never taken.
	assign take     = op_valid_in & (st_r.state == RSSD_ST_RUN);
	assign imm_form = (op_code_in == RSSD_OP_MINUS_IMM)
		| (op_code_in == RSSD_OP_SUBTRACT_WITH_BORROW_IMM);
	assign sub_rhs  = imm_form ? imm_data_in : mem_rd_data_in;

	rssd_subtractor u_sub (
		.minuend_in        (st_r.work),
		.subtrahend_in     (sub_rhs),
		.carry_in          (st_r.carry),
		.use_borrow_in     (rssd_uses_borrow(op_code_in)),
		.diff_out          (sub_diff),
		.carry_out         (sub_carry),
		.signed_wrap_out   (sub_wrap),
		.half_borrow_out   (sub_half),
		.signed_borrow_out (sub_sborrow),
		.zero_out          (sub_zero)
	);

	rssd_unary_unit u_unary (
		.op_in      (op_code_in),
		.operand_in (mem_rd_data_in),
		.carry_in   (st_r.carry),
		.bit_sel_in (bit_sel_in),
		.result_out (un_result),
		.carry_out  (un_carry),
		.skip_out   (un_skip)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] result;
		logic       is_sub;
		result          = RSSD_ZERO;
		is_sub          = rssd_is_subtract(op_code_in);
		st_nxt          = st_r;
		st_nxt.done     = 1'b0;
		st_nxt.cancel   = 1'b0;
		st_nxt.mem_we   = 1'b0;
		st_nxt.ready    = 1'b1;
		case (st_r.state)
			RSSD_ST_RUN: begin
				if (take) begin
					result      = is_sub ? sub_diff : un_result;
					st_nxt.done = 1'b1;
					st_nxt.addr = mem_addr_in;
					if (rssd_writes_mem(op_code_in)) begin
						st_nxt.mem_we = 1'b1;
						st_nxt.wdata  = result;
					end
					if (rssd_writes_work(op_code_in)) begin
						st_nxt.work = result;
					end
					if (is_sub) begin
						st_nxt.carry   = sub_carry;
						st_nxt.zero    = sub_zero;
						st_nxt.wrap    = sub_wrap;
						st_nxt.half    = sub_half;
						st_nxt.sborrow = sub_sborrow;
						// Chained forms keep a zero only if the earlier byte was zero too.
						st_nxt.cnull   = rssd_uses_borrow(op_code_in)
							? (sub_zero & st_r.cnull) : sub_zero;
					end else begin
						// Only the through-carry rotates change a flag at all.
						st_nxt.carry = un_carry;
					end
					if (un_skip && !is_sub) begin
						st_nxt.state  = RSSD_ST_CANCEL;
						st_nxt.ready  = 1'b0;
						st_nxt.cancel = 1'b1;
					end
				end
			end
			RSSD_ST_CANCEL: begin
				// The dummy cycle: whatever the sequencer shows now is dropped.
				st_nxt.state = RSSD_ST_RUN;
			end
			default: begin
				st_nxt.state = RSSD_ST_RUN;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_r.state   <= RSSD_ST_RUN;
			st_r.ready   <= 1'b0;
			st_r.done    <= 1'b0;
			st_r.cancel  <= 1'b0;
			st_r.mem_we  <= 1'b0;
			st_r.addr    <= '0;
			st_r.wdata   <= RSSD_ZERO;
			st_r.work    <= RSSD_WORK_RST;
			st_r.carry   <= RSSD_FLAG_RST;
			st_r.zero    <= RSSD_FLAG_RST;
			st_r.wrap    <= RSSD_FLAG_RST;
			st_r.half    <= RSSD_FLAG_RST;
			st_r.sborrow <= RSSD_FLAG_RST;
			st_r.cnull   <= RSSD_FLAG_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign mem_wr_en_out          = st_r.mem_we;
	assign mem_wr_addr_out        = st_r.addr;
	assign mem_wr_data_out        = st_r.wdata;
	assign ready_out              = st_r.ready;
	assign done_out               = st_r.done;
	assign cancel_out             = st_r.cancel;
	assign working_register_out   = st_r.work;
	assign carry_flag_out         = st_r.carry;
	assign zero_flag_out          = st_r.zero;
	assign signed_wrap_flag_out   = st_r.wrap;
	assign half_borrow_flag_out   = st_r.half;
	assign signed_borrow_flag_out = st_r.sborrow;
	assign chained_null_flag_out  = st_r.cnull;

endmodule

// ---- rssd_mem_model.sv ----
`timescale 1ns/1ps

// Data memory beside the block: the read is combinational because the block expects the
// operand byte in the same cycle as the operation; the write lands one edge after the pulse.
module rssd_mem_model #(
	parameter int unsigned ADDR_W = 8
)(
	// Clock
	input  wire logic              clk_in,
	// Read side
	input  wire logic [ADDR_W-1:0] rd_addr_in,
	output logic      [7:0]        rd_data_out,
	// Write side
	input  wire logic              wr_en_in,
	input  wire logic [ADDR_W-1:0] wr_addr_in,
	input  wire logic [7:0]        wr_data_in
);
	logic [7:0] mem [2**ADDR_W];

	assign rd_data_out = mem[rd_addr_in];

	always @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end
endmodule

// ---- rssd_datapath_checker.sv ----
`timescale 1ns/1ps

module rssd_datapath_checker
	import rssd_pkg::*;
#(
	parameter int unsigned ADDR_W = 8
)(
	// Clock, reset and operation
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              op_valid_in,
	input  rssd_pkg::rssd_op_type  op_code_in,
	input  wire logic [ADDR_W-1:0] mem_addr_in,
	input  wire logic [7:0]        mem_rd_data_in,
	input  wire logic [7:0]        imm_data_in,
	input  wire logic [2:0]        bit_sel_in,
	// Results
	input  wire logic              mem_wr_en_out,
	input  wire logic [ADDR_W-1:0] mem_wr_addr_out,
	input  wire logic [7:0]        mem_wr_data_out,
	input  wire logic              ready_out,
	input  wire logic              done_out,
	input  wire logic              cancel_out,
	input  wire logic [7:0]        working_register_out,
	input  wire logic              carry_flag_out,
	input  wire logic              zero_flag_out,
	input  wire logic              signed_wrap_flag_out,
	input  wire logic              half_borrow_flag_out,
	input  wire logic              signed_borrow_flag_out,
	input  wire logic              chained_null_flag_out
);
	// Checks start one edge after reset so that no past value reaches into reset.
	logic live_r;
	logic taken;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			live_r <= 1'b0;
		end else begin
			live_r <= 1'b1;
		end
	end
	assign taken = live_r && op_valid_in && !cancel_out;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	chk_rotl_mem:
	assert property (taken && op_code_in == RSSD_OP_ROTATE_LEFT_MEM |=> mem_wr_en_out &&
		mem_wr_data_out == {$past(mem_rd_data_in[6:0]), $past(mem_rd_data_in[7])} &&
		$stable(carry_flag_out)) else $error("rotate left result wrong");
	chk_rrc_work:
	assert property (taken && op_code_in == RSSD_OP_ROTATE_RIGHT_THRU_CARRY_TO_WORK |=>
		working_register_out == {$past(carry_flag_out), $past(mem_rd_data_in[7:1])} &&
		carry_flag_out == $past(mem_rd_data_in[0]) && !mem_wr_en_out)
		else $error("rotate right through carry wrong");
	chk_sub_carry:
	assert property (taken && op_code_in == RSSD_OP_MINUS_FROM_WORK |=> carry_flag_out ==
		($past(working_register_out) >= $past(mem_rd_data_in)) &&
		zero_flag_out == (working_register_out == 8'h00)) else $error("subtract flags wrong");
	chk_sbc_value:
	assert property (taken && op_code_in == RSSD_OP_SUBTRACT_WITH_BORROW |=>
		working_register_out == $past(working_register_out) - $past(mem_rd_data_in) -
		{7'h00, !$past(carry_flag_out)}) else $error("subtract with borrow wrong");
	chk_dec_skip:
	assert property (taken && op_code_in == RSSD_OP_DECREMENT_SKIP_ZERO |=> mem_wr_en_out &&
		mem_wr_data_out == $past(mem_rd_data_in) - 8'h01 &&
		cancel_out == ($past(mem_rd_data_in) == 8'h01)) else $error("decrement skip wrong");
	chk_skip_drop:
	assert property (cancel_out |-> !ready_out ##1 (!done_out && !mem_wr_en_out &&
		!cancel_out && ready_out)) else $error("cancelled cycle not dropped");
	chk_bit_set:
	assert property (taken && op_code_in == RSSD_OP_SET_BIT |=> mem_wr_data_out ==
		($past(mem_rd_data_in) | (8'h01 << $past(bit_sel_in))) && $stable(zero_flag_out))
		else $error("bit set wrong");
	chk_swap_nib:
	assert property (taken && op_code_in == RSSD_OP_SWAP_NIBBLES |=> mem_wr_data_out ==
		{$past(mem_rd_data_in[3:0]), $past(mem_rd_data_in[7:4])}) else $error("swap wrong");
	chk_nz_skip:
	assert property (taken && op_code_in == RSSD_OP_SKIP_IF_NONZERO |=> !mem_wr_en_out &&
		cancel_out == ($past(mem_rd_data_in) != 8'h00)) else $error("nonzero skip wrong");

	cover property (cancel_out);
	cover property (taken && op_code_in == RSSD_OP_SUBTRACT_WITH_BORROW);
	cover property (taken && op_code_in == RSSD_OP_MINUS_BORROW_INTO_MEM);
endmodule

bind rssd_datapath rssd_datapath_checker #(.ADDR_W(ADDR_W)) u_chk (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .op_valid_in(op_valid_in),
	.op_code_in(op_code_in), .mem_addr_in(mem_addr_in), .mem_rd_data_in(mem_rd_data_in),
	.imm_data_in(imm_data_in), .bit_sel_in(bit_sel_in), .mem_wr_en_out(mem_wr_en_out),
	.mem_wr_addr_out(mem_wr_addr_out), .mem_wr_data_out(mem_wr_data_out),
	.ready_out(ready_out), .done_out(done_out), .cancel_out(cancel_out),
	.working_register_out(working_register_out), .carry_flag_out(carry_flag_out),
	.zero_flag_out(zero_flag_out), .signed_wrap_flag_out(signed_wrap_flag_out),
	.half_borrow_flag_out(half_borrow_flag_out),
	.signed_borrow_flag_out(signed_borrow_flag_out),
	.chained_null_flag_out(chained_null_flag_out)
);

// ---- tb.sv ----
`timescale 1ns/1ps

module tb;
	import rssd_pkg::*;

	// ------------------------------------------------------------
	// Signals and expected state
	// ------------------------------------------------------------
	logic        clk_in     = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        vld        = 1'b0;
	rssd_op_type opc        = RSSD_OP_NOP;
	logic [7:0]  adr        = 8'h00;
	logic [7:0]  imm        = 8'h00;
	logic [2:0]  bs         = 3'h0;
	logic [7:0]  rdd, wa, wd, wk;
	logic        we, rdy, dn, cn, c, z, ov, hb, sb, cz;
	logic        ec = 1'b0, ez = 1'b0, ecz = 1'b0;
	logic [7:0]  imm_val    = 8'h00;
	int          errors = 0, cmp_count = 0, cyc = 0;

	always #4 clk_in = ~clk_in;

	rssd_datapath u_dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .op_valid_in(vld), .op_code_in(opc),
		.mem_addr_in(adr), .mem_rd_data_in(rdd), .imm_data_in(imm), .bit_sel_in(bs),
		.mem_wr_en_out(we), .mem_wr_addr_out(wa), .mem_wr_data_out(wd), .ready_out(rdy),
		.done_out(dn), .cancel_out(cn), .working_register_out(wk), .carry_flag_out(c),
		.zero_flag_out(z), .signed_wrap_flag_out(ov), .half_borrow_flag_out(hb),
		.signed_borrow_flag_out(sb), .chained_null_flag_out(cz)
	);
	rssd_mem_model u_mem (
		.clk_in(clk_in), .rd_addr_in(adr), .rd_data_out(rdd), .wr_en_in(we),
		.wr_addr_in(wa), .wr_data_in(wd)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// The constant comes from its own variable, so a wrong operand pick shows.
	task automatic present(input rssd_op_type o, input logic [7:0] a, input logic [2:0] s);
		@(posedge clk_in);
		vld <= 1'b1;
		opc <= o;
		adr <= a;
		bs <= s;
		imm <= imm_val;
	endtask

	task automatic run_op(input rssd_op_type o, input logic [7:0] a, input logic [2:0] s = 3'h0);
		present(o, a, s);
		@(posedge clk_in);
		vld <= 1'b0;
		#1;
		chk(dn, 1'b1);
		@(posedge clk_in);
		#1;
	endtask

	// Loads carry first, then the working register, without touching the other flags.
	task automatic prep(input logic [7:0] w, input logic ci);
		u_mem.mem[0] = {ci, 7'h00};
		run_op(RSSD_OP_ROTATE_LEFT_THRU_CARRY_TO_WORK, 8'h00);
		u_mem.mem[0] = {w[0], w[7:1]};
		run_op(RSSD_OP_ROTATE_LEFT_TO_WORK, 8'h00);
		ec = ci;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_rotates;
		logic [7:0] m;
		logic [7:0] e;
		logic nc;
		m = 8'h96;
		for (int i = 1; i <= 8; i++) begin
			prep(8'h00, i[1]);
			u_mem.mem[3] = m;
			run_op(rssd_op_type'(5'(i)), 8'h03);
			e = (i <= 4) ? {m[6:0], (i > 2) ? ec : m[7]} : {(i > 6) ? ec : m[0], m[7:1]};
			nc = (i == 3 || i == 4) ? m[7] : (i > 6) ? m[0] : ec;
			chk(i[0] ? u_mem.mem[3] : wk, e);
			chk(u_mem.mem[3], i[0] ? e : m);
			chk(c, nc);
			ec = nc;
		end
	endtask

	task automatic sub_case(input rssd_op_type o, input logic [7:0] w, b, input logic ci);
		logic isb, md, br, v, im;
		logic [7:0] mb;
		logic [5:0] ef;
		logic [8:0] d;
		logic [4:0] h;
		isb = (o == RSSD_OP_SUBTRACT_WITH_BORROW || o == RSSD_OP_SUBTRACT_WITH_BORROW_IMM ||
			o == RSSD_OP_MINUS_BORROW_INTO_MEM);
		md = (o == RSSD_OP_MINUS_INTO_MEM || o == RSSD_OP_MINUS_BORROW_INTO_MEM);
		im = (o == RSSD_OP_MINUS_IMM || o == RSSD_OP_SUBTRACT_WITH_BORROW_IMM);
		mb = im ? ~b : b;
		br = isb && !ci;
		prep(w, ci);
		imm_val = b;
		u_mem.mem[1] = mb;
		run_op(o, 8'h01);
		d = {1'b0, w} - {1'b0, b} - {8'h00, br};
		h = {1'b0, w[3:0]} - {1'b0, b[3:0]} - {4'h0, br};
		v = (w[7] != b[7]) && (d[7] != w[7]);
		ez = (d[7:0] == 8'h00);
		ecz = isb ? (ez && ecz) : ez;
		ec = !d[8];
		ef = {ec, ez, v, !h[4], v ^ d[7], ecz};
		chk(md ? u_mem.mem[1] : wk, d[7:0]);
		chk(md ? wk : u_mem.mem[1], md ? w : mb);
		chk({c, z, ov, hb, sb, cz}, ef);
	endtask

	task automatic t_subs;
		logic [7:0] wv[4] = '{8'h50, 8'h30, 8'h80, 8'h44};
		logic [7:0] bv[4] = '{8'h30, 8'h50, 8'h01, 8'h44};
		for (int i = 9; i <= 14; i++) begin
			for (int j = 0; j < 4; j++) begin
				sub_case(rssd_op_type'(5'(i)), wv[j], bv[j], j[0]);
			end
		end
		// A plain zero, then a borrow-form zero, must keep the chained flag set.
		sub_case(RSSD_OP_MINUS_FROM_WORK, 8'h44, 8'h44, 1'b1);
		sub_case(RSSD_OP_SUBTRACT_WITH_BORROW, 8'h44, 8'h44, 1'b1);
	endtask

	// A byte-set is offered right behind the skip; a taken skip must drop it.
	task automatic skip_case(input rssd_op_type o, input logic [7:0] m, input logic [2:0] s,
		input logic sk);
		logic [7:0] r;
		logic wdst;
		// A known working value shows whether a memory-form skip left it alone.
		prep(8'h5a, ec);
		u_mem.mem[0] = m;
		u_mem.mem[2] = 8'h00;
		present(o, 8'h00, s);
		present(RSSD_OP_SET_BYTE, 8'h02, 3'h0);
		#1;
		chk(cn, sk);
		chk(rdy, !sk);
		@(posedge clk_in);
		vld <= 1'b0;
		#1;
		chk(dn, !sk);
		@(posedge clk_in);
		#1;
		chk(u_mem.mem[2], sk ? 8'h00 : 8'hff);
		wdst = (o == RSSD_OP_DECREMENT_SKIP_TO_WORK || o == RSSD_OP_INCREMENT_SKIP_TO_WORK);
		r = (o <= RSSD_OP_DECREMENT_SKIP_TO_WORK) ? m - 8'h01 : m + 8'h01;
		if (o >= RSSD_OP_SKIP_IF_NONZERO) begin
			r = m;
		end
		chk(u_mem.mem[0], wdst ? m : r);
		chk(wk, wdst ? r : 8'h5a);
		chk({c, z, cz}, {ec, ez, ecz});
	endtask

	task automatic t_skips;
		for (int i = 15; i <= 18; i++) begin
			skip_case(rssd_op_type'(5'(i)), (i <= 16) ? 8'h01 : 8'hff, 3'h0, 1'b1);
			skip_case(rssd_op_type'(5'(i)), 8'h10, 3'h0, 1'b0);
		end
		skip_case(RSSD_OP_SKIP_IF_NONZERO, 8'h20, 3'h0, 1'b1);
		skip_case(RSSD_OP_SKIP_IF_NONZERO, 8'h00, 3'h0, 1'b0);
		skip_case(RSSD_OP_SKIP_IF_NONZERO_BIT, 8'h20, 3'h5, 1'b1);
		skip_case(RSSD_OP_SKIP_IF_NONZERO_BIT, 8'h20, 3'h4, 1'b0);
	endtask

	task automatic t_bits;
		for (int i = 0; i < 8; i++) begin
			u_mem.mem[4] = 8'h10;
			run_op(RSSD_OP_SET_BIT, 8'h04, 3'(i));
			chk(u_mem.mem[4], 8'h10 | (8'h01 << i));
		end
		u_mem.mem[4] = 8'h5a;
		run_op(RSSD_OP_SET_BYTE, 8'h04);
		chk(u_mem.mem[4], RSSD_ALL_ONES);
		u_mem.mem[4] = 8'h3c;
		run_op(RSSD_OP_SWAP_NIBBLES, 8'h04);
		chk(u_mem.mem[4], 8'hc3);
		chk({c, z, cz}, {ec, ez, ecz});
	endtask

	// ------------------------------------------------------------
	// Main sequence and hang guard
	// ------------------------------------------------------------
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 4000) begin
			errors++;
			complete_run;
		end
	end

	initial begin
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk(rdy, 1'b1);
		chk({wk, c, z, cz}, {RSSD_WORK_RST, {3{RSSD_FLAG_RST}}});
		t_rotates;
		t_subs;
		t_skips;
		t_bits;
		complete_run;
	end
endmodule
